// ===== rtl/clock_power_reset_regs.vh
// register map, field positions and timing constants of the clock block
`ifndef CLOCK_POWER_RESET_REGS_VH
`define CLOCK_POWER_RESET_REGS_VH

`define ADDR_BT_CTRL      8'hD3
`define ADDR_SYS_CLK      8'hD4
`define ADDR_CHAR_SIZE    8'h10
`define ADDR_DISP_CTRL    8'h11
`define ADDR_PWR_CMD      8'h12
`define ADDR_STATUS       8'h13
`define ADDR_IRQ_CTRL     8'h14

`define SYS_CLK_RESET     8'h98
`define SYS_CLK_WAKE_BIT  7
`define SYS_CLK_STOP_BIT  6
`define SYS_CLK_DIV_HI    4
`define SYS_CLK_DIV_LO    3
`define SYS_CLK_SRC_HI    2
`define SYS_CLK_SRC_LO    0
`define SRC_INVALID       3'h5

`define BT_CTRL_RESET     8'h00
`define BT_WDT_HI         7
`define BT_WDT_LO         4
`define BT_WDT_OFF        4'hA
`define BT_STAB_HI        3
`define BT_STAB_LO        2
`define BT_CLEAR_BIT      1

`define CHAR_SIZE_RESET   8'h00
`define CHAR_DIV_HI       5
`define CHAR_DIV_LO       4
`define DISP_CTRL_RESET   8'h00
`define DISP_LC_EN_BIT    0

`define PWR_IDLE_BIT      0
`define PWR_STOP_BIT      1
`define IRQ_GLOBAL_BIT    0

`define ST_RUN_BIT        0
`define ST_IDLE_BIT       1
`define ST_STOP_BIT       2
`define ST_STAB_BIT       3
`define ST_WDT_EN_BIT     4
`define ST_OSC_ON_BIT     5
`define ST_WDT_RST_BIT    6

`define RESET_VECTOR      16'h0100
`define P0_OUT_DEFAULT    8'hC0
`define P1_OUT_DEFAULT    8'h3F
`define P2_OUT_DEFAULT    8'h00
`define P3_OUT_DEFAULT    8'hFF

`define FILTER_CYCLES     3'h4
`define REF_CLK_MHZ       20
`define RESET_HOLD_US     1000
`define RESET_HOLD_CYCLES (`REF_CLK_MHZ * `RESET_HOLD_US)

`endif

// ===== rtl/sync2.v
// two flip-flop synchroniser for levels arriving from pins
`timescale 1ns/100ps
`default_nettype none
module sync2
#(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
  input  wire             i_clk,   // destination clock
  input  wire             i_reset, // async reset, active high
  input  wire [WIDTH-1:0] i_async, // level from outside the domain
  output reg  [WIDTH-1:0] o_sync   // level safe to use
);

  reg [WIDTH-1:0] meta_q;

  // first stage feeds only the second one
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_q <= INIT;
      o_sync <= INIT;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cpu_clk_div.v
// cpu clock enable divider with boundary-only ratio switching
`timescale 1ns/100ps
`default_nettype none
module cpu_clk_div
(
  input  wire       i_clk,   // reference clock
  input  wire       i_reset, // async reset, active high
  input  wire       i_clear, // synchronous restart
  input  wire [1:0] i_sel,   // 00 /1, 01 /2, 10 /8, 11 /16
  output reg        o_tick   // one pulse per divided period
);

  reg [3:0] cnt_q;
  reg [1:0] sel_q;

  // terminal count of each ratio
  function [3:0] last_count;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    last_count = 4'h0;
        2'h1:    last_count = 4'h1;
        2'h2:    last_count = 4'h7;
        default: last_count = 4'hF;
      endcase
    end
  endfunction

  // new ratio is taken only at a period end, so no runt period
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q  <= 4'h0;
      sel_q  <= 2'h3;
      o_tick <= 1'b0;
    end
    else if (i_clear)
    begin
      cnt_q  <= 4'h0;
      sel_q  <= 2'h3;
      o_tick <= 1'b0;
    end
    else if (cnt_q >= last_count(sel_q))
    begin
      cnt_q  <= 4'h0;
      sel_q  <= i_sel;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + 4'h1;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/clock_power_reset_ctrl.v
// clock, power-down and reset sequencing control of the microcontroller
`timescale 1ns/100ps
`default_nettype none
`include "clock_power_reset_regs.vh"
module clock_power_reset_ctrl
#(
  parameter STAB_BASE_CYCLES = 256,
  parameter WDT_CYCLES       = 65535
)
(
  input  wire        i_ref_clk,       // 20 MHz reference clock
  input  wire        i_reset,         // async reset, active high
  input  wire        i_reset_n_pin,   // reset pin, active low
  input  wire        i_ext_irq,       // external interrupt pin
  input  wire        i_irq_any,       // any pending interrupt
  input  wire        i_hsync,         // horizontal sync pin
  input  wire        i_vsync,         // vertical sync pin
  input  wire [7:0]  i_addr,          // register address
  input  wire [7:0]  i_wdata,         // register write data
  input  wire        i_wr,            // write strobe
  input  wire        i_rd,            // read strobe
  output reg  [7:0]  o_rdata,         // read data, cycle after read
  output reg         o_main_osc_en,   // main oscillator running
  output reg         o_cpu_clk_en,    // cpu clock enable pulse
  output reg         o_periph_clk_en, // gated peripheral clock enable
  output reg         o_exempt_clk_en, // display/timer a/pwm/capture
  output reg  [2:0]  o_clk_src_sel,   // clock source code
  output reg         o_lc_osc_en,     // lc oscillator run
  output reg  [1:0]  o_disp_div_sel,  // display clock divider
  output reg         o_line_start,    // new display line pulse
  output reg         o_frame_start,   // new frame pulse
  output reg         o_sys_reset,     // system reset to peripherals
  output reg         o_irq_global_en, // interrupts enabled
  output reg         o_wdt_en,        // watchdog reset armed
  output reg         o_pc_load,       // load program counter pulse
  output reg  [15:0] o_pc_vector,     // reset vector
  output reg         o_fetch_en,      // instruction fetch allowed
  output reg  [7:0]  o_p0_out_en,     // port 0 open-drain outputs
  output reg  [7:0]  o_p1_out_en,     // port 1 open-drain outputs
  output reg  [7:0]  o_p2_out_en,     // port 2 open-drain outputs
  output reg  [7:0]  o_p3_out_en      // port 3 open-drain outputs
);

  // one-hot power states
  localparam [3:0] S_RUN  = 4'h1;
  localparam [3:0] S_IDLE = 4'h2;
  localparam [3:0] S_STOP = 4'h4;
  localparam [3:0] S_STAB = 4'h8;

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [7:0]  sys_clk_q;
  reg  [7:0]  bt_ctrl_q;
  reg  [7:0]  char_size_q;
  reg  [7:0]  disp_ctrl_q;
  reg         irq_en_q;
  reg         wdt_rst_flag_q;
  reg         wdt_fire_q;
  reg  [15:0] bt_cnt_q;
  reg  [2:0]  filt_cnt_q;
  reg         ext_filt_q;
  reg         hsync_q;
  reg         vsync_q;
  reg         rst_soft_q;
  wire        pin_n_sync;
  wire        ext_sync;
  wire        hsync_sync;
  wire        vsync_sync;
  wire        cpu_tick;
  wire        rst_soft;
  wire        wr_sys;
  wire        wr_bt;
  wire        wr_pwr;
  wire        ext_wake;
  wire        wdt_armed;
  wire        osc_run;
  wire [15:0] stab_len;
  reg  [7:0]  status;

  // register write decode
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input       wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // stabilisation length: base times 1, 4, 16 or 64
  function [15:0] stab_cycles;
    input [1:0] sel;
    reg   [15:0] base;
    begin
      base        = STAB_BASE_CYCLES[15:0];
      stab_cycles = base << {sel, 1'b0};
    end
  endfunction

  // pin-level inputs pass two flops before any logic
  sync2 #(.WIDTH(1), .INIT(1'b0)) u_rst_pin_sync
  (
    .i_clk   (i_ref_clk),
    .i_reset (i_reset),
    .i_async (i_reset_n_pin),
    .o_sync  (pin_n_sync)
  );

  sync2 #(.WIDTH(3), .INIT(3'h0)) u_pin_sync
  (
    .i_clk   (i_ref_clk),
    .i_reset (i_reset),
    .i_async ({i_ext_irq, i_hsync, i_vsync}),
    .o_sync  ({ext_sync, hsync_sync, vsync_sync})
  );

  cpu_clk_div u_cpu_clk_div
  (
    .i_clk   (i_ref_clk),
    .i_reset (i_reset),
    .i_clear (rst_soft),
    .i_sel   (sys_clk_q[`SYS_CLK_DIV_HI:`SYS_CLK_DIV_LO]),
    .o_tick  (cpu_tick)
  );

  // synchronised pin reset or watchdog overflow resets the system
  assign rst_soft  = !pin_n_sync || wdt_fire_q;
  assign wr_sys    = wr_hit(i_addr, `ADDR_SYS_CLK, i_wr);
  assign wr_bt     = wr_hit(i_addr, `ADDR_BT_CTRL, i_wr);
  assign wr_pwr    = wr_hit(i_addr, `ADDR_PWR_CMD, i_wr);
  assign wdt_armed = bt_ctrl_q[`BT_WDT_HI:`BT_WDT_LO] != `BT_WDT_OFF;
  assign ext_wake  = ext_filt_q && sys_clk_q[`SYS_CLK_WAKE_BIT];
  assign osc_run   = !state_q[2] && !sys_clk_q[`SYS_CLK_STOP_BIT];
  assign stab_len  = stab_cycles(bt_ctrl_q[`BT_STAB_HI:`BT_STAB_LO]);

  // noise filter: interrupt level must hold several cycles to count
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      filt_cnt_q <= 3'h0;
      ext_filt_q <= 1'b0;
    end
    else if (!ext_sync)
    begin
      filt_cnt_q <= 3'h0;
      ext_filt_q <= 1'b0;
    end
    else if (filt_cnt_q == `FILTER_CYCLES)
    begin
      ext_filt_q <= 1'b1;
    end
    else
    begin
      filt_cnt_q <= filt_cnt_q + 3'h1;
    end
  end

  // software registers; soft reset restores every default
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sys_clk_q   <= `SYS_CLK_RESET;
      bt_ctrl_q   <= `BT_CTRL_RESET;
      char_size_q <= `CHAR_SIZE_RESET;
      disp_ctrl_q <= `DISP_CTRL_RESET;
      irq_en_q    <= 1'b0;
    end
    else if (rst_soft)
    begin
      sys_clk_q   <= `SYS_CLK_RESET;
      bt_ctrl_q   <= `BT_CTRL_RESET;
      char_size_q <= `CHAR_SIZE_RESET;
      disp_ctrl_q <= `DISP_CTRL_RESET;
      irq_en_q    <= 1'b0;
    end
    else
    begin
      if (wr_sys)
      begin
        sys_clk_q[7:3] <= i_wdata[7:3];
        // the missing subsystem source is refused, old code kept
        if (i_wdata[`SYS_CLK_SRC_HI:`SYS_CLK_SRC_LO] != `SRC_INVALID)
        begin
          sys_clk_q[2:0] <= i_wdata[2:0];
        end
      end
      if (wr_bt)
      begin
        bt_ctrl_q <= i_wdata;
      end
      if (wr_hit(i_addr, `ADDR_CHAR_SIZE, i_wr))
      begin
        char_size_q <= i_wdata;
      end
      if (wr_hit(i_addr, `ADDR_DISP_CTRL, i_wr))
      begin
        disp_ctrl_q <= i_wdata;
      end
      if (wr_hit(i_addr, `ADDR_IRQ_CTRL, i_wr))
      begin
        irq_en_q <= i_wdata[`IRQ_GLOBAL_BIT];
      end
    end
  end

  // power state sequencing
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RUN:
      begin
        if (wr_pwr && i_wdata[`PWR_STOP_BIT])
          state_d = S_STOP;
        else if (wr_pwr && i_wdata[`PWR_IDLE_BIT])
          state_d = S_IDLE;
      end
      S_IDLE:
      begin
        if (i_irq_any || ext_wake)
          state_d = S_RUN;
      end
      S_STOP:
      begin
        if (ext_wake)
          state_d = S_STAB;
      end
      S_STAB:
      begin
        if (bt_cnt_q >= stab_len)
          state_d = S_RUN;
      end
      default:
        state_d = S_STAB;
    endcase
  end

  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state_q <= S_STAB;
    else if (rst_soft)
      state_q <= S_STAB;
    else
      state_q <= state_d;
  end

  // basic timer: frozen with the oscillator, restarted for each wait
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      bt_cnt_q   <= 16'h0000;
      wdt_fire_q <= 1'b0;
    end
    else if (rst_soft || (state_q[2] && ext_wake))
    begin
      bt_cnt_q   <= 16'h0000;
      wdt_fire_q <= 1'b0;
    end
    else if (wr_bt && i_wdata[`BT_CLEAR_BIT])
    begin
      bt_cnt_q   <= 16'h0000;
      wdt_fire_q <= 1'b0;
    end
    else if (osc_run)
    begin
      if (bt_cnt_q == WDT_CYCLES[15:0])
      begin
        bt_cnt_q   <= 16'h0000;
        wdt_fire_q <= wdt_armed;
      end
      else
      begin
        bt_cnt_q   <= bt_cnt_q + 16'h0001;
        wdt_fire_q <= 1'b0;
      end
    end
    else
    begin
      wdt_fire_q <= 1'b0;
    end
  end

  // watchdog cause flag survives the reset it causes; set beats clear
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      wdt_rst_flag_q <= 1'b0;
    else if (wdt_fire_q)
      wdt_rst_flag_q <= 1'b1;
    else if (wr_hit(i_addr, `ADDR_STATUS, i_wr) &&
             i_wdata[`ST_WDT_RST_BIT])
      wdt_rst_flag_q <= 1'b0;
  end

  // status word seen by software
  always @*
  begin
    status                  = 8'h00;
    status[`ST_RUN_BIT]     = state_q[0];
    status[`ST_IDLE_BIT]    = state_q[1];
    status[`ST_STOP_BIT]    = state_q[2];
    status[`ST_STAB_BIT]    = state_q[3];
    status[`ST_WDT_EN_BIT]  = wdt_armed;
    status[`ST_OSC_ON_BIT]  = osc_run;
    status[`ST_WDT_RST_BIT] = wdt_rst_flag_q;
  end

  // read port; unmapped and command addresses read zero
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        `ADDR_SYS_CLK:   o_rdata <= sys_clk_q;
        `ADDR_BT_CTRL:   o_rdata <= bt_ctrl_q;
        `ADDR_CHAR_SIZE: o_rdata <= char_size_q;
        `ADDR_DISP_CTRL: o_rdata <= disp_ctrl_q;
        `ADDR_STATUS:    o_rdata <= status;
        `ADDR_IRQ_CTRL:  o_rdata <= {7'h00, irq_en_q};
        default:         o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // clock gating: idle stops cpu and peripherals, exempt units run on
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_main_osc_en   <= 1'b1;
      o_cpu_clk_en    <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_exempt_clk_en <= 1'b0;
      o_clk_src_sel   <= 3'h0;
    end
    else
    begin
      o_main_osc_en   <= osc_run;
      o_cpu_clk_en    <= cpu_tick && osc_run &&
                         (state_q[0] || state_q[3]);
      o_periph_clk_en <= cpu_tick && osc_run && state_q[0];
      o_exempt_clk_en <= cpu_tick && osc_run;
      o_clk_src_sel   <= sys_clk_q[`SYS_CLK_SRC_HI:`SYS_CLK_SRC_LO];
    end
  end

  // display timing: lc oscillator gated by enable and sync blanking
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      hsync_q        <= 1'b0;
      vsync_q        <= 1'b0;
      o_lc_osc_en    <= 1'b0;
      o_disp_div_sel <= 2'h0;
      o_line_start   <= 1'b0;
      o_frame_start  <= 1'b0;
    end
    else
    begin
      hsync_q        <= hsync_sync;
      vsync_q        <= vsync_sync;
      o_lc_osc_en    <= disp_ctrl_q[`DISP_LC_EN_BIT] &&
                        !hsync_sync && !vsync_sync;
      o_disp_div_sel <= char_size_q[`CHAR_DIV_HI:`CHAR_DIV_LO];
      o_line_start   <= hsync_sync && !hsync_q;
      o_frame_start  <= vsync_sync && !vsync_q;
    end
  end

  // reset sequence outputs; fetch waits out the stabilisation state
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rst_soft_q      <= 1'b1;
      o_sys_reset     <= 1'b1;
      o_irq_global_en <= 1'b0;
      o_wdt_en        <= 1'b1;
      o_pc_load       <= 1'b0;
      o_pc_vector     <= `RESET_VECTOR;
      o_fetch_en      <= 1'b0;
    end
    else
    begin
      rst_soft_q      <= rst_soft;
      o_sys_reset     <= rst_soft;
      o_irq_global_en <= irq_en_q && !rst_soft;
      o_wdt_en        <= wdt_armed;
      o_pc_load       <= rst_soft_q && !rst_soft;
      o_pc_vector     <= `RESET_VECTOR;
      o_fetch_en      <= !rst_soft && !state_q[3] && !state_q[2];
    end
  end

  // port defaults; pins driven here are open-drain outputs
  always @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_p0_out_en <= `P0_OUT_DEFAULT;
      o_p1_out_en <= `P1_OUT_DEFAULT;
      o_p2_out_en <= `P2_OUT_DEFAULT;
      o_p3_out_en <= `P3_OUT_DEFAULT;
    end
    else if (rst_soft)
    begin
      o_p0_out_en <= `P0_OUT_DEFAULT;
      o_p1_out_en <= `P1_OUT_DEFAULT;
      o_p2_out_en <= `P2_OUT_DEFAULT;
      o_p3_out_en <= `P3_OUT_DEFAULT;
    end
  end

endmodule
`default_nettype wire

// ===== test/clock_power_reset_ctrl_asserts.sv
// assertion checker of the clock, power-down and reset control block
`timescale 1ns/100ps
`default_nettype none
module clock_power_reset_ctrl_asserts
#(
  parameter STAB_BASE_CYCLES = 256,
  parameter WDT_CYCLES       = 65535
)
(
  input wire logic        i_ref_clk,       // reference clock
  input wire logic        i_reset,         // async reset, active high
  input wire logic        i_hsync,         // horizontal sync pin
  input wire logic        i_vsync,         // vertical sync pin
  input wire logic [7:0]  i_addr,          // register address
  input wire logic [7:0]  i_wdata,         // register write data
  input wire logic        i_wr,            // write strobe
  input wire logic        i_rd,            // read strobe
  input wire logic [7:0]  o_rdata,         // read data
  input wire logic        o_main_osc_en,   // main oscillator run
  input wire logic        o_cpu_clk_en,    // cpu clock pulse
  input wire logic        o_periph_clk_en, // peripheral clock pulse
  input wire logic        o_exempt_clk_en, // exempt units pulse
  input wire logic [2:0]  o_clk_src_sel,   // clock source code
  input wire logic        o_lc_osc_en,     // lc oscillator run
  input wire logic        o_line_start,    // new line pulse
  input wire logic        o_sys_reset,     // system reset
  input wire logic        o_irq_global_en, // interrupts enabled
  input wire logic        o_wdt_en,        // watchdog armed
  input wire logic        o_pc_load,       // load program counter
  input wire logic [15:0] o_pc_vector,     // reset vector
  input wire logic        o_fetch_en,      // fetch allowed
  input wire logic [7:0]  o_p0_out_en,     // port 0 outputs
  input wire logic [7:0]  o_p1_out_en,     // port 1 outputs
  input wire logic [7:0]  o_p2_out_en,     // port 2 outputs
  input wire logic [7:0]  o_p3_out_en      // port 3 outputs
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // steps of the sync and oscillator-halt behaviours
  sequence hs_rise;
    !i_hsync ##1 i_hsync;
  endsequence
  sequence blank4;
    (i_hsync || i_vsync) [*4];
  endsequence
  sequence halted2;
    (!o_main_osc_en) [*2];
  endsequence

  // read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data seen without a read");
  a_src_legal: assert property (o_clk_src_sel != 3'h5)
    else $error("clock source code took the invalid value");
  a_lc_blank: assert property (blank4 |-> !o_lc_osc_en)
    else $error("lc oscillator ran during blanking");
  // a settled sync edge must give a line pulse within a short bound
  a_line_rise: assert property (hs_rise ##0 !o_sys_reset |->
    ##[1:5] o_line_start)
    else $error("no line start after hsync rise");
  a_osc_halt: assert property (halted2 |-> !o_cpu_clk_en &&
    !o_periph_clk_en && !o_exempt_clk_en)
    else $error("clock pulse while main oscillator halted");
  a_periph_sub: assert property (o_periph_clk_en |->
    o_cpu_clk_en && o_exempt_clk_en)
    else $error("peripheral pulse outside cpu pulse");
  a_wdt_off: assert property (i_wr && i_addr == 8'hD3 &&
    i_wdata[7:4] == 4'hA && !o_sys_reset |-> ##[1:2] !o_wdt_en)
    else $error("watchdog still armed after disable code");
  a_reset_state: assert property (o_sys_reset ##1 o_sys_reset |->
    o_wdt_en && !o_irq_global_en && o_p0_out_en == 8'hC0 &&
    o_p1_out_en == 8'h3F && o_p2_out_en == 8'h00 &&
    o_p3_out_en == 8'hFF)
    else $error("reset state of ports or interrupts wrong");
  // fetch must stay off for the three cycles after the load
  a_pc_vector: assert property (o_pc_load |-> o_pc_vector == 16'h0100
    ##1 (!o_fetch_en) [*3])
    else $error("reset vector wrong or fetch too early");
endmodule

bind clock_power_reset_ctrl clock_power_reset_ctrl_asserts
#(.STAB_BASE_CYCLES(STAB_BASE_CYCLES), .WDT_CYCLES(WDT_CYCLES)) chk
(
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_hsync(i_hsync),
  .i_vsync(i_vsync), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_main_osc_en(o_main_osc_en),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
  .o_exempt_clk_en(o_exempt_clk_en), .o_clk_src_sel(o_clk_src_sel),
  .o_lc_osc_en(o_lc_osc_en), .o_line_start(o_line_start),
  .o_sys_reset(o_sys_reset), .o_irq_global_en(o_irq_global_en),
  .o_wdt_en(o_wdt_en), .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector),
  .o_fetch_en(o_fetch_en), .o_p0_out_en(o_p0_out_en),
  .o_p1_out_en(o_p1_out_en), .o_p2_out_en(o_p2_out_en),
  .o_p3_out_en(o_p3_out_en)
);
`default_nettype wire

// ===== test/ext_party_model.sv
// model of the reset source and the sync generator outside the block
`timescale 1ns/100ps
`default_nettype none
module ext_party_model
#(
  parameter HOLD_CYCLES = 20000, // one millisecond at 50 ns
  parameter KICK_CYCLES = 8
)
(
  input  wire logic i_clk,         // reference clock
  input  wire logic i_reset,       // high until supply is valid
  input  wire logic i_kick,        // request a short reset pulse
  input  wire logic i_sync_on,     // run the raster syncs
  output var  logic o_reset_n_pin, // reset pin, active low
  output var  logic o_hsync,       // horizontal sync, high = blank
  output var  logic o_vsync        // vertical sync, high = blank
);
  logic [14:0] hold_q;
  logic [6:0]  raster_q;

  // the pin stays low a full interval after power comes up
  always @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      hold_q        <= HOLD_CYCLES;
      o_reset_n_pin <= 1'b0;
    end
    else if (i_kick)
    begin
      hold_q        <= KICK_CYCLES;
      o_reset_n_pin <= 1'b0;
    end
    else if (hold_q != 15'h0000)
      hold_q <= hold_q - 15'h0001;
    else
      o_reset_n_pin <= 1'b1;
  end

  // lines of 32 cycles, 4 lines a frame; the display oscillator is
  // not modelled, so its rate against the cpu clock is free
  always @(posedge i_clk)
  begin
    raster_q <= i_sync_on ? raster_q + 7'h01 : 7'h00;
    o_hsync  <= i_sync_on && raster_q[4:3] == 2'b00;
    o_vsync  <= i_sync_on && raster_q[6:5] == 2'b00;
  end
endmodule
`default_nettype wire

// ===== test/test_clock_power_reset_ctrl.sv
// self-checking bench of the clock, power-down and reset control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  failures++; $display("wrong value %s expected %h seen %h", nm, e, g); \
  end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) \
  begin @(posedge i_ref_clk); #1; end
module test_clock_power_reset_ctrl;
  localparam int WDT = 2000;
  localparam int SH[4] = '{0, 1, 3, 4};
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_ext_irq = 1'b0;
  logic i_irq_any = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic kick = 1'b0, sync_on = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, v;
  wire logic pin_n, hs, vs, osc, cpu, per, exm, lc, ln, fr, srst, irq_en;
  wire logic wdt, fetch;
  wire logic [7:0] rdata, p0, p1, p2, p3;
  wire logic [2:0] src;
  wire logic [1:0] ddiv;
  wire logic [15:0] pcv;
  int failures = 0, tests_run = 0, cycles = 0;
  int n_cpu, n_per, n_exm, n_ln, n_fr;

  clock_power_reset_ctrl #(.STAB_BASE_CYCLES(4), .WDT_CYCLES(WDT)) dut
  (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reset_n_pin(pin_n),
    .i_ext_irq(i_ext_irq), .i_irq_any(i_irq_any), .i_hsync(hs),
    .i_vsync(vs), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .o_main_osc_en(osc), .o_cpu_clk_en(cpu),
    .o_periph_clk_en(per), .o_exempt_clk_en(exm), .o_clk_src_sel(src),
    .o_lc_osc_en(lc), .o_disp_div_sel(ddiv), .o_line_start(ln),
    .o_frame_start(fr), .o_sys_reset(srst), .o_irq_global_en(irq_en),
    .o_wdt_en(wdt), .o_pc_load(), .o_pc_vector(pcv), .o_fetch_en(fetch),
    .o_p0_out_en(p0), .o_p1_out_en(p1), .o_p2_out_en(p2), .o_p3_out_en(p3)
  );
  ext_party_model party
  (
    .i_clk(i_ref_clk), .i_reset(i_reset), .i_kick(kick),
    .i_sync_on(sync_on), .o_reset_n_pin(pin_n), .o_hsync(hs), .o_vsync(vs)
  );

  always #25 i_ref_clk = ~i_ref_clk;

  // a hang ends the run as a failure
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  // read data is taken in the one cycle where it stands
  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK("register", e, v)
  endtask

  // counts pulses over a window, sampling after each edge settles
  task automatic window(input int len);
    repeat (len)
    begin
      @(posedge i_ref_clk);
      #1;
      n_cpu += cpu;
      n_per += per;
      n_exm += exm;
      n_ln  += ln;
      n_fr  += fr;
    end
  endtask

  task automatic clr();
    {n_cpu, n_per, n_exm, n_ln, n_fr} = '0;
  endtask

  // one pin reset pulse from the external source
  task automatic pin_reset();
    @(posedge i_ref_clk);
    kick <= 1'b1;
    @(posedge i_ref_clk);
    kick <= 1'b0;
    `WAIT(srst, 20)
    `WAIT(!srst, 40)
  endtask

  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    #1 `CHK("ports", 32'hC03F_00FF, {p0, p1, p2, p3})
    `CHK("watchdog", 1'b1, wdt)
    `CHK("irq enable", 1'b0, irq_en)
    window(19000);
    `CHK("held reset", 1'b1, srst)
    `WAIT(!srst, 2000)
    `CHK("reset vector", 16'h0100, pcv)
    wr(8'hD3, 8'hA0);
    window(1);
    `CHK("fetch wait", 1'b0, fetch)
    `CHK("watchdog off", 1'b0, wdt)
    rdc(8'hD4, 8'h98);
    `CHK("source", 3'h0, src)
    `CHK("osc on", 1'b1, osc)
    rdc(8'hD3, 8'hA0);
    rdc(8'h12, 8'h00);
    rdc(8'h55, 8'h00);
    // every divider ratio, counted over a whole number of periods
    for (int s = 0; s < 4; s++)
    begin
      wr(8'hD4, 8'h80 | (s << 3));
      window(40);
      clr();
      window(64);
      `CHK("cpu pulses", 64 >> SH[s], n_cpu)
      `CHK("periph pulses", 64 >> SH[s], n_per)
    end
    wr(8'hD4, 8'h8A);
    wr(8'hD4, 8'h9D);
    rdc(8'hD4, 8'h9A);
    `CHK("source kept", 3'h2, src)
    `CHK("lc off", 1'b0, lc)
    wr(8'h11, 8'h01);
    wr(8'h10, 8'h30);
    window(3);
    `CHK("lc on", 1'b1, lc)
    `CHK("display div", 2'b11, ddiv)
    sync_on <= 1'b1;
    clr();
    window(512);
    `CHK("lines", 1'b1, n_ln >= 15 && n_ln <= 17)
    `CHK("frames", 1'b1, n_fr >= 3 && n_fr <= 5)
    sync_on <= 1'b0;
    // idle keeps exempt units clocked; any interrupt ends it
    wr(8'hD4, 8'h80);
    wr(8'h12, 8'h01);
    window(20);
    clr();
    window(32);
    `CHK("idle periph", 0, n_per)
    `CHK("idle exempt", 32, n_exm)
    i_irq_any <= 1'b1;
    @(posedge i_ref_clk);
    i_irq_any <= 1'b0;
    clr();
    window(16);
    `CHK("idle exit", 1'b1, n_per > 8)
    // the stop bit alone halts the main oscillator
    wr(8'hD4, 8'hC0);
    window(2);
    `CHK("stop bit osc", 1'b0, osc)
    wr(8'hD4, 8'h80);
    // stop released by a filtered external interrupt
    wr(8'h12, 8'h02);
    window(3);
    `CHK("stop osc", 1'b0, osc)
    `CHK("stop fetch", 1'b0, fetch)
    i_ext_irq <= 1'b1;
    `WAIT(osc, 40)
    `CHK("wake osc", 1'b1, osc)
    `WAIT(fetch, 200)
    `CHK("wake fetch", 1'b1, fetch)
    i_ext_irq <= 1'b0;
    window(10);
    // with wake disabled only a reset ends stop
    wr(8'h14, 8'h01);
    window(2);
    `CHK("irq enable set", 1'b1, irq_en)
    wr(8'hD4, 8'h00);
    wr(8'h12, 8'h02);
    i_ext_irq <= 1'b1;
    window(40);
    `CHK("no wake", 1'b0, osc)
    i_ext_irq <= 1'b0;
    pin_reset();
    `CHK("reset wake", 1'b1, osc)
    `CHK("irq off", 1'b0, irq_en)
    `CHK("wdt armed", 1'b1, wdt)
    rdc(8'hD4, 8'h98);
    // an armed watchdog overflow resets the system
    `WAIT(srst, WDT + 100)
    `CHK("wdt reset", 1'b1, srst)
    `WAIT(!srst, 40)
    rd(8'h13);
    `CHK("wdt status", 1'b1, v[6])
    wr(8'hD3, 8'hA0);
    conclude();
  end
endmodule
`default_nettype wire
